// ==== design/cal_sequencer.sv ====
// VCO calibration sequencer on a divided phase detector clock
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"

module cal_sequencer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       pfdTick,
  input  wire logic [1:0] calDivSel,
  output logic            busy_q,
  output logic            internalSync_q,
  output logic            loopOpen_q,
  output logic            done_q
);

  pll_ctl_pkg::cal_state_t state_q;
  logic [4:0]              divCnt_q;
  logic [12:0]             tickCnt_q;
  logic [4:0]              divisor;
  logic                    calTick;

  // Calibration clock is the phase detector rate over 2, 4, 8 or 16
  assign divisor = `CAL_DIV_BASE << calDivSel; // RL19
  assign calTick = (state_q == pll_ctl_pkg::CAL_RUN) && pfdTick && (divCnt_q == divisor - 5'h01);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_n || start)
      divCnt_q <= 5'h00;
    else if (pfdTick && state_q == pll_ctl_pkg::CAL_RUN)
      divCnt_q <= calTick ? 5'h00 : divCnt_q + 5'h01; // RL19
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q        <= pll_ctl_pkg::CAL_IDLE;
      tickCnt_q      <= 13'h0000;
      busy_q         <= 1'b0;
      internalSync_q <= 1'b0;
      loopOpen_q     <= 1'b0;
      done_q         <= 1'b0;
    end
    else if (start)
    begin
      // Outputs go static and the loop opens while the VCO is tuned
      state_q        <= pll_ctl_pkg::CAL_RUN;
      tickCnt_q      <= 13'h0000;
      busy_q         <= 1'b1;
      internalSync_q <= 1'b1; // RL18
      loopOpen_q     <= 1'b1;
      done_q         <= 1'b0; // RL24
    end
    else if (calTick)
    begin
      tickCnt_q <= tickCnt_q + 13'h0001;
      // Sync drops one tick before the loop closes: outputs may run unsettled
      if (tickCnt_q == `CAL_CYCLES - 13'h0002)
        internalSync_q <= 1'b0; // RL18
      if (tickCnt_q == `CAL_CYCLES - 13'h0001) // RL20
      begin
        state_q    <= pll_ctl_pkg::CAL_IDLE;
        busy_q     <= 1'b0;
        loopOpen_q <= 1'b0; // RL18
        done_q     <= 1'b1; // RL17
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_cal_length: assert property (@(posedge clk) disable iff (!rst_n) // RL20
    $rose(done_q) |-> $past(calTick) && ($past(tickCnt_q) == `CAL_CYCLES - 13'h0001))
    else $error("calibration ended at the wrong tick count");

  a_sync_in_open: assert property (@(posedge clk) disable iff (!rst_n) // RL18
    internalSync_q |-> loopOpen_q && !done_q)
    else $error("sync held with the loop closed");

  a_sync_before_close: assert property (@(posedge clk) disable iff (!rst_n) // RL18
    $fell(loopOpen_q) && !$past(start) |-> !$past(internalSync_q))
    else $error("loop closed before sync release");

endmodule : cal_sequencer

// ==== design/lock_detector.sv ====
// Digital lock detector counting in-window phase detector cycles
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"

module lock_detector (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       pfdTick,
  input  wire logic       inLockWin,
  input  wire logic       inUnlockWin,
  input  wire logic [1:0] countSel,
  output logic            locked_q
);

  logic [7:0] cnt_q;
  logic [7:0] need;

  always_comb
  begin
    unique case (countSel)
      2'b00: need = `LD_CNT_CODE0;
      2'b01: need = `LD_CNT_CODE1;
      2'b10: need = `LD_CNT_CODE2;
      2'b11: need = `LD_CNT_CODE3;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_n || !enable)
    begin
      cnt_q    <= 8'h00;
      locked_q <= 1'b0;
    end
    else if (pfdTick)
    begin
      if (locked_q)
      begin
        // Wider unlock window keeps the indicator from chattering
        if (!inUnlockWin) // RL23
        begin
          locked_q <= 1'b0;
          cnt_q    <= 8'h00;
        end
      end
      else if (inLockWin)
      begin
        if (cnt_q + 8'h01 >= need) // RL7
          locked_q <= 1'b1;
        else
          cnt_q <= cnt_q + 8'h01;
      end
      else
        cnt_q <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_unlock_one_cycle: assert property (@(posedge clk) disable iff (!rst_n) // RL23
    (enable && locked_q && pfdTick && !inUnlockWin) |=> !locked_q)
    else $error("lock held past an out-of-window cycle");

  a_lock_count_met: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    $rose(locked_q) |-> ($past(cnt_q) + 8'h01 >= $past(need)) && $past(inLockWin))
    else $error("lock indicated before enough cycles");

endmodule : lock_detector

// ==== design/pll_ctl_cfg.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PLL_CTL_CFG_SVH
`define PLL_CTL_CFG_SVH

`define PLL_ADDR_W            10
`define PLL_DATA_W            8

`define PLL_ADDR_LOCK_CAL     10'h018
`define PLL_ADDR_LD_PIN_SEL   10'h01a
`define PLL_ADDR_REF_MON      10'h01b
`define PLL_ADDR_REF_CTL      10'h01c
`define PLL_ADDR_HOLD_CTL     10'h01d
`define PLL_ADDR_STATUS       10'h01f
`define PLL_ADDR_UPDATE       10'h232

`define PLL_RST_LOCK_CAL      8'h00
`define PLL_RST_LD_PIN_SEL    6'h00
`define PLL_RST_REF_MON       8'h00
`define PLL_RST_REF_CTL       8'h00
`define PLL_RST_HOLD_CTL      8'h00

`define LC_CAL_BIT            0
`define LC_CALDIV_LSB         1
`define LC_DLD_DIS_BIT        3
`define LC_LDCNT_LSB          5
`define HC_EN_A_BIT           0
`define HC_EXT_BIT            1
`define HC_EN_B_BIT           2
`define HC_CMP_BIT            3
`define RC_REFERENCE_SELECT_PIN_BIT         6
`define RM_THRESH_LSB         5
`define UPD_BIT               0

`define ST_DLD_BIT            0
`define ST_MON_LSB            1
`define ST_HOLD_BIT           4
`define ST_CAL_BUSY_BIT       5
`define ST_CAL_DONE_BIT       6

`define LD_SEL_CUR_SRC        6'h04

`define LD_CNT_CODE0          8'h05
`define LD_CNT_CODE1          8'h10
`define LD_CNT_CODE2          8'h40
`define LD_CNT_CODE3          8'hff

`define CAL_CYCLES            13'h1130
`define CAL_DIV_BASE          5'h02

`endif

// ==== design/pll_ctl_pkg.sv ====
// Types shared by the holdover and calibration control blocks
package pll_ctl_pkg;

  typedef struct packed {
    logic [7:0] lockCal;
    logic [5:0] ldPinSel;
    logic [7:0] reference_monitor_pin;
    logic [7:0] refCtl;
    logic [7:0] holdCtl;
  } cfg_t;

  typedef enum logic [2:0] {
    HO_ARMED = 3'b001,
    HO_HOLD  = 3'b010,
    HO_REACQ = 3'b100
  } hold_state_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } cal_state_t;

endpackage : pll_ctl_pkg

// ==== design/pll_holdover_vco_cal_control.sv ====
// Automatic holdover and VCO calibration control with register port
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"

// What the document requires of this block and of its software
// (RL1) Lock pin level triggers holdover entry
// (RL2) Comparator disabled: lock pin read high
// (RL3) Charge pump high-Z until reference edge
// (RL4) Exit edge resets B counter, not prescaler
// (RL5) No re-entry before relock and pin high
// (RL6) Holdover follows selected reference edge
// (RL7) Lock counter code 00 means five cycles
// (RL8) Software keeps digital lock detect enabled
// (RL9) Code 000100 selects current-source lock mode
// (RL10) Software should prefer current-source lock mode
// (RL11) External control bit zero selects automatic
// (RL12) Both enable bits needed for any holdover
// (RL13) Software calibrates before enabling holdover
// (RL14) Monitor threshold select and low status
// (RL15) First calibration: set calibrate bit, update
// (RL16) Later calibration: clear, update, set, update
// (RL17) Done readback bit set after calibration
// (RL18) Sync, tune, release sync, close loop
// (RL19) Calibration clock is divided PHASE_FREQ_DETECTOR rate
// (RL20) Calibration lasts 4400 calibration clocks
// (RL21) Calibration starts only by software
// (RL22) Software disables holdover, supplies reference
// (RL23) Lock held until one cycle exceeds unlock
// (RL24) Done bit clear from start to completion
module pll_holdover_vco_cal_control (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  output logic      [7:0] rdData_q,
  input  wire logic       ref1Pin,
  input  wire logic       ref2Pin,
  input  wire logic       inLockWinPin,
  input  wire logic       inUnlockWinPin,
  input  wire logic       lockPinCmp,
  input  wire logic       holdPin_n,
  input  wire logic       ref1LowPin,
  input  wire logic       ref2LowPin,
  input  wire logic       vcoLowPin,
  output logic            cpHighZ_q,
  output logic            bCounterReset_q,
  output logic            internalSync_q,
  output logic            loopOpen_q,
  output logic            dldLocked_q,
  output logic            csLockMode_q,
  output logic      [5:0] lockPinSel_q,
  output logic            refSelect_q,
  output logic      [2:0] monThreshold_q
);

  localparam int NSYNC = 9;

  pll_ctl_pkg::cfg_t        stage_q;
  pll_ctl_pkg::cfg_t        active_q;
  pll_ctl_pkg::hold_state_t holdSt_q;

  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncA_q;
  logic [NSYNC-1:0] syncB_q;
  logic [1:0]       refPrev_q;
  logic             ref1Tick;
  logic             ref2Tick;
  logic             refTick;
  logic             calStart_q;
  logic             calBusy;
  logic             calDone;
  logic             dldLocked;
  logic             holdEnable;
  logic             extMode;
  logic             cmpEn;
  logic             ldSensed;
  logic             holdPinHigh;
  logic             trigger;
  logic             exitOk;
  logic [7:0]       status;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pinRaw = {vcoLowPin, ref2LowPin, ref1LowPin, holdPin_n, lockPinCmp,
                   inUnlockWinPin, inLockWinPin, ref2Pin, ref1Pin};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          syncA_q[gi] <= 1'b0;
          syncB_q[gi] <= 1'b0;
        end
        else
        begin
          syncA_q[gi] <= pinRaw[gi];
          syncB_q[gi] <= syncA_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      refPrev_q <= 2'b00;
    else
      refPrev_q <= syncB_q[1:0];
  end

  assign ref1Tick = syncB_q[0] && !refPrev_q[0];
  assign ref2Tick = syncB_q[1] && !refPrev_q[1];
  // Only the reference now in use can end a holdover
  assign refTick  = active_q.refCtl[`RC_REFERENCE_SELECT_PIN_BIT] ? ref2Tick : ref1Tick; // RL6

  //////////////////////////////////////////////////////////////////////////////
  // Register port: writes land in staging, update copies to active
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage_q.lockCal  <= `PLL_RST_LOCK_CAL;
      stage_q.ldPinSel <= `PLL_RST_LD_PIN_SEL;
      stage_q.reference_monitor_pin   <= `PLL_RST_REF_MON;
      stage_q.refCtl   <= `PLL_RST_REF_CTL;
      stage_q.holdCtl  <= `PLL_RST_HOLD_CTL;
    end
    else if (wrEn)
    begin
      unique case (addr)
        `PLL_ADDR_LOCK_CAL:   stage_q.lockCal  <= wrData;
        `PLL_ADDR_LD_PIN_SEL: stage_q.ldPinSel <= wrData[5:0];
        `PLL_ADDR_REF_MON:    stage_q.reference_monitor_pin   <= wrData;
        `PLL_ADDR_REF_CTL:    stage_q.refCtl   <= wrData;
        `PLL_ADDR_HOLD_CTL:   stage_q.holdCtl  <= wrData;
        default:              ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      active_q.lockCal  <= `PLL_RST_LOCK_CAL;
      active_q.ldPinSel <= `PLL_RST_LD_PIN_SEL;
      active_q.reference_monitor_pin   <= `PLL_RST_REF_MON;
      active_q.refCtl   <= `PLL_RST_REF_CTL;
      active_q.holdCtl  <= `PLL_RST_HOLD_CTL;
    end
    else if (wrEn && addr == `PLL_ADDR_UPDATE && wrData[`UPD_BIT])
      active_q <= stage_q;
  end

  // Only a 0-to-1 of the applied calibrate bit starts a run; setting changes never do
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      calStart_q <= 1'b0;
    else
      calStart_q <= wrEn && addr == `PLL_ADDR_UPDATE && wrData[`UPD_BIT]
                    && stage_q.lockCal[`LC_CAL_BIT] && !active_q.lockCal[`LC_CAL_BIT]; // RL21
  end

  assign status = {1'b0, calDone, calBusy, holdSt_q != pll_ctl_pkg::HO_ARMED,
                   syncB_q[8:6], dldLocked}; // RL14 RL17

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdData_q <= 8'h00;
    else if (rdEn)
    begin
      unique case (addr)
        `PLL_ADDR_LOCK_CAL:   rdData_q <= stage_q.lockCal;
        `PLL_ADDR_LD_PIN_SEL: rdData_q <= {2'b00, stage_q.ldPinSel};
        `PLL_ADDR_REF_MON:    rdData_q <= stage_q.reference_monitor_pin;
        `PLL_ADDR_REF_CTL:    rdData_q <= stage_q.refCtl;
        `PLL_ADDR_HOLD_CTL:   rdData_q <= stage_q.holdCtl;
        `PLL_ADDR_STATUS:     rdData_q <= status;
        default:              rdData_q <= 8'h00;
      endcase
    end
    else
      rdData_q <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lock detection and pin configuration
  lock_detector u_lock (
    .clk         (clk),
    .rst_n       (rst_n),
    .enable      (!active_q.lockCal[`LC_DLD_DIS_BIT]),
    .pfdTick     (refTick),
    .inLockWin   (syncB_q[2]),
    .inUnlockWin (syncB_q[3]),
    .countSel    (active_q.lockCal[`LC_LDCNT_LSB +: 2]),
    .locked_q    (dldLocked)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dldLocked_q    <= 1'b0;
      csLockMode_q   <= 1'b0;
      lockPinSel_q   <= `PLL_RST_LD_PIN_SEL;
      refSelect_q    <= 1'b0;
      monThreshold_q <= 3'h0;
    end
    else
    begin
      dldLocked_q    <= dldLocked;
      csLockMode_q   <= active_q.ldPinSel == `LD_SEL_CUR_SRC; // RL9
      lockPinSel_q   <= active_q.ldPinSel;
      refSelect_q    <= active_q.refCtl[`RC_REFERENCE_SELECT_PIN_BIT];
      monThreshold_q <= active_q.reference_monitor_pin[`RM_THRESH_LSB +: 3]; // RL14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Holdover state machine
  assign holdEnable  = active_q.holdCtl[`HC_EN_A_BIT] && active_q.holdCtl[`HC_EN_B_BIT]; // RL12
  assign extMode     = active_q.holdCtl[`HC_EXT_BIT]; // RL11
  assign cmpEn       = active_q.holdCtl[`HC_CMP_BIT];
  assign ldSensed    = cmpEn ? syncB_q[4] : 1'b1; // RL2
  assign holdPinHigh = syncB_q[5];
  assign trigger     = extMode ? !holdPinHigh : !ldSensed; // RL1
  // External hold also waits for its pin to return high
  assign exitOk      = refTick && !(extMode && !holdPinHigh); // RL3

  always_ff @(posedge clk)
  begin
    if (!rst_n || !holdEnable)
    begin
      holdSt_q        <= pll_ctl_pkg::HO_ARMED;
      cpHighZ_q       <= 1'b0; // RL12
      bCounterReset_q <= 1'b0;
    end
    else
    begin
      bCounterReset_q <= 1'b0;
      unique case (holdSt_q)
        pll_ctl_pkg::HO_ARMED:
          if (trigger) // RL1
          begin
            holdSt_q  <= pll_ctl_pkg::HO_HOLD;
            cpHighZ_q <= 1'b1;
          end
        pll_ctl_pkg::HO_HOLD:
          if (exitOk) // RL3 RL6
          begin
            holdSt_q        <= pll_ctl_pkg::HO_REACQ;
            cpHighZ_q       <= 1'b0;
            bCounterReset_q <= 1'b1; // RL4
          end
        pll_ctl_pkg::HO_REACQ:
          // Chattering lock would otherwise retrigger holdover at once
          if (extMode || (dldLocked && ldSensed)) // RL5
            holdSt_q <= pll_ctl_pkg::HO_ARMED;
        default:
        begin
          holdSt_q  <= pll_ctl_pkg::HO_ARMED;
          cpHighZ_q <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // VCO calibration
  cal_sequencer u_cal (
    .clk            (clk),
    .rst_n          (rst_n),
    .start          (calStart_q),
    .pfdTick        (refTick),
    .calDivSel      (active_q.lockCal[`LC_CALDIV_LSB +: 2]),
    .busy_q         (calBusy),
    .internalSync_q (internalSync_q),
    .loopOpen_q     (loopOpen_q),
    .done_q         (calDone)
  );

  //////////////////////////////////////////////////////////////////////////////
  a_hold_disabled: assert property (@(posedge clk) disable iff (!rst_n) // RL12
    !holdEnable |=> !cpHighZ_q && holdSt_q == pll_ctl_pkg::HO_ARMED)
    else $error("charge pump high-Z with holdover disabled");

  a_hold_entry: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    (holdEnable && holdSt_q == pll_ctl_pkg::HO_ARMED && !extMode && !ldSensed) |=> cpHighZ_q)
    else $error("lost lock did not enter holdover");

  a_cmp_off_no_hold: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    (holdSt_q == pll_ctl_pkg::HO_ARMED && !extMode && !cmpEn) |=> !cpHighZ_q)
    else $error("holdover entered with comparator disabled");

  a_ext_mode_pin: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    (holdSt_q == pll_ctl_pkg::HO_ARMED && extMode && holdPinHigh) |=> !cpHighZ_q)
    else $error("external mode entered holdover without pin");

  a_hiz_until_ref: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    (cpHighZ_q && holdEnable && !refTick) |=> cpHighZ_q)
    else $error("charge pump released without reference edge");

  a_breset_on_exit: assert property (@(posedge clk) disable iff (!rst_n) // RL4
    (holdSt_q == pll_ctl_pkg::HO_HOLD && holdEnable && exitOk) |=> bCounterReset_q && !cpHighZ_q)
    else $error("B counter not reset on holdover exit");

  a_no_reentry: assert property (@(posedge clk) disable iff (!rst_n) // RL5
    (holdSt_q == pll_ctl_pkg::HO_REACQ && !extMode && !dldLocked) |=> !cpHighZ_q[*2])
    else $error("holdover re-entered before relock");

  a_cs_mode: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    ##1 (csLockMode_q == ($past(active_q.ldPinSel) == `LD_SEL_CUR_SRC)))
    else $error("current-source mode decode wrong");

  a_cal_sw_only: assert property (@(posedge clk) disable iff (!rst_n) // RL21
    $rose(calBusy) |-> $past(calStart_q))
    else $error("calibration started without software");

  a_done_cleared: assert property (@(posedge clk) disable iff (!rst_n) // RL24
    calStart_q |=> !calDone[*3])
    else $error("done bit not cleared at calibration start");

endmodule : pll_holdover_vco_cal_control

// ==== tb/tb.sv ====
// Self-checking bench for holdover and VCO calibration control
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"

module tb;
  logic       clk;
  logic       rst_n;
  logic [9:0] addr;
  logic [7:0] wrData;
  logic       wrEn;
  logic       rdEn;
  logic [7:0] rdData_q;
  logic       ref1Pin;
  logic       ref2Pin;
  logic       holdPin_n;
  logic       inLockWinPin;
  logic       inUnlockWinPin;
  logic       lockPinCmp;
  logic       cpHighZ_q;
  logic       bCounterReset_q;
  logic       internalSync_q;
  logic       loopOpen_q;
  logic       dldLocked_q;
  logic       csLockMode_q;
  logic [5:0] lockPinSel_q;
  logic       refSelect_q;
  logic [2:0] monThreshold_q;
  logic [7:0] rv;
  int         num_errors = 0;
  int         compares = 0;
  int         bcrCount = 0;
  int         n;

  ////////////////////////////////////////////////////////////////////////////////
  // Monitors fixed at 101; second reference and external hold driven by the tests
  pll_holdover_vco_cal_control u_pll_holdover_vco_cal_control (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData_q(rdData_q), .ref1Pin(ref1Pin), .ref2Pin(ref2Pin), .inLockWinPin(inLockWinPin),
    .inUnlockWinPin(inUnlockWinPin), .lockPinCmp(lockPinCmp), .holdPin_n(holdPin_n),
    .ref1LowPin(1'b1), .ref2LowPin(1'b0), .vcoLowPin(1'b1), .cpHighZ_q(cpHighZ_q),
    .bCounterReset_q(bCounterReset_q), .internalSync_q(internalSync_q), .loopOpen_q(loopOpen_q),
    .dldLocked_q(dldLocked_q), .csLockMode_q(csLockMode_q), .lockPinSel_q(lockPinSel_q),
    .refSelect_q(refSelect_q), .monThreshold_q(monThreshold_q));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
    if (bCounterReset_q === 1'b1)
      bcrCount <= bcrCount + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk);
    wrEn   <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe: sampled at its closing edge
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    @(posedge clk);
    d = rdData_q;
  endtask : rd

  task automatic upd;
    wr(`PLL_ADDR_UPDATE, 8'h01);
  endtask : upd

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask : idle

  // Four-cycle reference period: long enough for the two-flop synchroniser
  task automatic pulses(input int k);
    repeat (k)
    begin
      @(posedge clk);
      ref1Pin <= 1'b1;
      idle(2);
      ref1Pin <= 1'b0;
      idle(1);
    end
    idle(6);
  endtask : pulses

  initial
  begin
    idle(100000);
    num_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    addr = 10'h000;
    wrData = 8'h00;
    wrEn = 1'b0;
    rdEn = 1'b0;
    ref1Pin = 1'b0;
    ref2Pin = 1'b0;
    holdPin_n = 1'b1;
    inLockWinPin = 1'b0;
    inUnlockWinPin = 1'b1;
    lockPinCmp = 1'b1;
    idle(8);
    rst_n <= 1'b1;
    rd(`PLL_ADDR_HOLD_CTL, rv);
    check(rv, 8'h00);
    rd(`PLL_ADDR_STATUS, rv);
    check(rv, 8'h0a);
    wr(`PLL_ADDR_STATUS, 8'hff);
    rd(`PLL_ADDR_STATUS, rv);
    check(rv, 8'h0a);
    rd(10'h3ff, rv);
    check(rv, 8'h00);
    wr(`PLL_ADDR_LD_PIN_SEL, `LD_SEL_CUR_SRC);
    wr(`PLL_ADDR_REF_MON, 8'ha0);
    upd();
    idle(3);
    check(csLockMode_q, 1'b1);
    check(lockPinSel_q, 6'h04);
    check(monThreshold_q, 3'b101);
    $display("registers test done");
    // Calibration with divider code 0: two reference ticks per cal clock
    wr(`PLL_ADDR_LOCK_CAL, 8'h01);
    upd();
    idle(3);
    check(internalSync_q, 1'b1);
    check(loopOpen_q, 1'b1);
    rd(`PLL_ADDR_STATUS, rv);
    check(rv[`ST_CAL_DONE_BIT], 1'b0);
    pulses(8796);
    check(internalSync_q, 1'b1);
    pulses(2);
    check(internalSync_q, 1'b0);
    check(loopOpen_q, 1'b1);
    pulses(2);
    check(loopOpen_q, 1'b0);
    rd(`PLL_ADDR_STATUS, rv);
    check(rv[`ST_CAL_DONE_BIT], 1'b1);
    upd();
    idle(3);
    check(internalSync_q, 1'b0);
    $display("calibration test done");
    inLockWinPin <= 1'b1;
    idle(4);
    pulses(4);
    check(dldLocked_q, 1'b0);
    pulses(1);
    check(dldLocked_q, 1'b1);
    inLockWinPin <= 1'b0;
    idle(4);
    pulses(3);
    check(dldLocked_q, 1'b1);
    inUnlockWinPin <= 1'b0;
    idle(4);
    pulses(1);
    check(dldLocked_q, 1'b0);
    inLockWinPin <= 1'b1;
    inUnlockWinPin <= 1'b1;
    idle(4);
    pulses(5);
    $display("lock detect test done");
    wr(`PLL_ADDR_HOLD_CTL, 8'h0d);
    upd();
    lockPinCmp <= 1'b0;
    idle(6);
    check(cpHighZ_q, 1'b1);
    rd(`PLL_ADDR_STATUS, rv);
    check(rv, 8'h5b);
    idle(40);
    check(cpHighZ_q, 1'b1);
    n = bcrCount;
    pulses(1);
    check(cpHighZ_q, 1'b0);
    check(bcrCount - n, 1);
    idle(10);
    check(cpHighZ_q, 1'b0);
    // Lock lost while reacquiring: still no re-entry
    inUnlockWinPin <= 1'b0;
    pulses(1);
    check(dldLocked_q, 1'b0);
    check(cpHighZ_q, 1'b0);
    inUnlockWinPin <= 1'b1;
    lockPinCmp <= 1'b1;
    pulses(5);
    lockPinCmp <= 1'b0;
    idle(6);
    check(cpHighZ_q, 1'b1);
    lockPinCmp <= 1'b1;
    pulses(1);
    check(cpHighZ_q, 1'b0);
    // Comparator off: a low pin must not be seen
    wr(`PLL_ADDR_HOLD_CTL, 8'h05);
    upd();
    lockPinCmp <= 1'b0;
    idle(8);
    check(cpHighZ_q, 1'b0);
    wr(`PLL_ADDR_HOLD_CTL, 8'h09);
    upd();
    idle(8);
    check(cpHighZ_q, 1'b0);
    wr(`PLL_ADDR_HOLD_CTL, 8'h0c);
    upd();
    idle(8);
    check(cpHighZ_q, 1'b0);
    wr(`PLL_ADDR_HOLD_CTL, 8'h0d);
    upd();
    idle(8);
    check(cpHighZ_q, 1'b1);
    wr(`PLL_ADDR_REF_CTL, 8'h40);
    upd();
    idle(3);
    check(refSelect_q, 1'b1);
    pulses(1);
    check(cpHighZ_q, 1'b1);
    // Edge on the selected second reference ends the hold
    ref2Pin <= 1'b1;
    idle(4);
    ref2Pin <= 1'b0;
    idle(6);
    check(cpHighZ_q, 1'b0);
    // External control: only the hold pin may trigger
    wr(`PLL_ADDR_HOLD_CTL, 8'h07);
    upd();
    idle(8);
    check(cpHighZ_q, 1'b0);
    holdPin_n <= 1'b0;
    idle(6);
    check(cpHighZ_q, 1'b1);
    wr(`PLL_ADDR_HOLD_CTL, 8'h00);
    upd();
    idle(3);
    check(cpHighZ_q, 1'b0);
    lockPinCmp <= 1'b1;
    holdPin_n <= 1'b1;
    wr(`PLL_ADDR_REF_CTL, 8'h00);
    $display("holdover test done");
    wr(`PLL_ADDR_LOCK_CAL, 8'h00);
    upd();
    wr(`PLL_ADDR_LOCK_CAL, 8'h01);
    upd();
    idle(3);
    check(internalSync_q, 1'b1);
    rd(`PLL_ADDR_STATUS, rv);
    check(rv[`ST_CAL_DONE_BIT], 1'b0);
    $display("recalibration test done");
    conclude();
  end
endmodule : tb
